// file: verilog/irq_ctrl_map.vh
`ifndef IRQ_CTRL_MAP_VH
`define IRQ_CTRL_MAP_VH
// ==========================================
// Register indices (printed offsets), byte address = 4 * index
`define REG_PRIORITY_CTRL_A 16'hFEE8
`define REG_PRIORITY_CTRL_B 16'hFEE9
`define REG_PRIORITY_CTRL_C 16'hFEEA
`define REG_PIN_PENDING_FLAGS 16'hFEEB
`define REG_SENSE_CTRL_HIGH 16'hFEEC
`define REG_SENSE_CTRL_LOW 16'hFEED
`define REG_IRQ_STATUS 16'hFEF0
`define REG_IRQ_MASK 16'hFEF1
// ==========================================
// Reset values
`define RST_BYTE 8'h00
`define RST_PINS 3'h7
// ==========================================
// Priority bit positions
`define PA_EXT0 7
`define PA_EXT1 6
`define PA_EXT2 5
`define PA_XFER 2
`define PA_WDOG0 1
`define PA_WDOG1 0
`define PB_CONV 7
`define PB_FRT 6
`define PB_TMR1 2
`define PB_TMRXY 1
`define PC_SER0 7
`define PC_SER1 6
`define PC_TWC0 4
`define PC_TWC1 3
// ==========================================
// Sense modes (B,A)
`define SENSE_LOW 2'h0
`define SENSE_FALL 2'h1
`define SENSE_RISE 2'h2
`define SENSE_BOTH 2'h3
`define NUM_PINS 3
`define NUM_SRC 14
`endif

// file: verilog/pin_sense.v
`timescale 1ns/1ps
`include "irq_ctrl_map.vh"
// ==========================================
// One pin: synchroniser, sense detect, pending flag
module pin_sense (
	input wire pclk,
	input wire presetn,
	input wire pin_async,
	input wire [1:0] sense_mode,
	input wire clr_by_write,
	input wire exc_ack,
	output wire pin_level,
	output wire set_event,
	output reg flag_r
);
	reg sync1_r;
	reg sync2_r;
	reg prev_r;
	reg flag_nxt;
	wire fall;
	wire rise;
	reg hit;

	// ==========================================
	// Two-stage synchroniser plus one history stage
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_r <= 1'b1;
			sync2_r <= 1'b1;
			prev_r <= 1'b1;
		end else begin
			sync1_r <= pin_async;
			sync2_r <= sync1_r;
			prev_r <= sync2_r; // RULE9
		end
	end

	assign pin_level = sync2_r;
	assign fall = prev_r & ~sync2_r; // RULE9
	assign rise = ~prev_r & sync2_r; // RULE9

	always @* begin
		case (sense_mode) // RULE3
			`SENSE_LOW: hit = ~sync2_r;
			`SENSE_FALL: hit = fall;
			`SENSE_RISE: hit = rise;
			`SENSE_BOTH: hit = fall | rise;
			default: hit = 1'b0;
		endcase
	end
	assign set_event = hit;

	// Set wins over any clear in the same cycle
	always @* begin
		flag_nxt = flag_r;
		if (clr_by_write) begin
			flag_nxt = 1'b0; // RULE5
		end
		if (exc_ack && sense_mode == `SENSE_LOW && sync2_r) begin
			flag_nxt = 1'b0; // RULE6
		end
		if (exc_ack && sense_mode != `SENSE_LOW) begin
			flag_nxt = 1'b0; // RULE7
		end
		if (hit) begin
			flag_nxt = 1'b1; // RULE4
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_r <= 1'b0;
		end else begin
			flag_r <= flag_nxt;
		end
	end
endmodule // pin_sense

// file: verilog/ext_irq_sense_priority_ctrl.v
`timescale 1ns/1ps
`include "irq_ctrl_map.vh"
// Operation
// RULE1 - A priority bit of 0 puts its source at control level 0, a 1 at control level 1.
// RULE2 - Priority bits map to sources: A 7/6/5 pins, 2 transfer, 1/0 watchdogs; B 7 conv, 6 FRT, 2 timer1, 1 timers XY; C 7/6 serial, 4/3 two-wire.
// RULE3 - Sense pair (B,A) selects 00 low level, 01 falling, 10 rising, 11 both edges.
// RULE4 - A pin's pending flag sets when the pin meets its selected sense condition.
// RULE5 - A pending flag is cleared by writing 0 after it was read as 1, and only so by software; the arm takes the access-phase flag, not the value read.
// RULE6 - In low-level mode exception handling clears the flag when the pin is high.
// RULE7 - In edge modes exception handling for the pin clears its flag.
// RULE8 - Writing 1 to a pending flag leaves it unchanged; only 0 acts.
// RULE9 - Pins are sampled on the clock and edges found from consecutive samples.
module ext_irq_sense_priority_ctrl (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [2:0] ext_interrupt_pin,
	input wire [2:0] exc_ack,
	output wire [2:0] pin_request,
	output wire [2:0] pin_priority,
	output wire [13:0] src_priority,
	output wire irq
);
	reg [7:0] priority_ctrl_a_r;
	reg [7:0] priority_ctrl_b_r;
	reg [7:0] priority_ctrl_c_r;
	reg [7:0] sense_ctrl_high_r;
	reg [7:0] sense_ctrl_low_r;
	reg [2:0] read_one_r;
	reg [2:0] status_r;
	reg [2:0] mask_r;
	reg [2:0] status_nxt;
	reg [2:0] read_one_nxt;
	wire [2:0] flag;
	wire [2:0] set_ev;
	wire [2:0] clr_wr;
	wire [2:0] status_clr;
	reg [31:0] prdata_nxt;
	wire prio_pin0;
	wire prio_pin1;
	wire prio_pin2;
	wire prio_xfer;
	wire prio_wdog0;
	wire prio_wdog1;
	wire prio_conv;
	wire prio_frt;
	wire prio_tmr1;
	wire prio_tmrxy;
	wire prio_ser0;
	wire prio_ser1;
	wire prio_twc0;
	wire prio_twc1;
	wire [29:0] idx;
	wire acc;
	wire wr;
	wire rd;
	wire sel_a;
	wire sel_b;
	wire sel_c;
	wire sel_f;
	wire sel_h;
	wire sel_l;
	wire sel_s;
	wire sel_m;
	wire mapped;

	// ==========================================
	// APB decode: zero-wait, word per register
	assign idx = paddr[31:2];
	assign acc = psel & penable;
	assign wr = acc & pwrite & pstrb[0];
	assign rd = acc & ~pwrite;
	assign sel_a = (idx == {14'h0000, `REG_PRIORITY_CTRL_A});
	assign sel_b = (idx == {14'h0000, `REG_PRIORITY_CTRL_B});
	assign sel_c = (idx == {14'h0000, `REG_PRIORITY_CTRL_C});
	assign sel_f = (idx == {14'h0000, `REG_PIN_PENDING_FLAGS});
	assign sel_h = (idx == {14'h0000, `REG_SENSE_CTRL_HIGH});
	assign sel_l = (idx == {14'h0000, `REG_SENSE_CTRL_LOW});
	assign sel_s = (idx == {14'h0000, `REG_IRQ_STATUS});
	assign sel_m = (idx == {14'h0000, `REG_IRQ_MASK});
	assign mapped = sel_a | sel_b | sel_c | sel_f | sel_h | sel_l | sel_s | sel_m;
	assign pready = 1'b1;
	assign pslverr = acc & ~mapped;

	// ==========================================
	// Control registers, one process each
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			priority_ctrl_a_r <= `RST_BYTE;
		end else if (wr && sel_a) begin
			priority_ctrl_a_r <= pwdata[7:0]; // RULE1
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			priority_ctrl_b_r <= `RST_BYTE;
		end else if (wr && sel_b) begin
			priority_ctrl_b_r <= pwdata[7:0]; // RULE1
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			priority_ctrl_c_r <= `RST_BYTE;
		end else if (wr && sel_c) begin
			priority_ctrl_c_r <= pwdata[7:0]; // RULE1
		end
	end

	// Reserved byte kept as plain storage
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sense_ctrl_high_r <= `RST_BYTE;
		end else if (wr && sel_h) begin
			sense_ctrl_high_r <= pwdata[7:0];
		end
	end

	// Top two bits unused, always read 0
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sense_ctrl_low_r <= `RST_BYTE;
		end else if (wr && sel_l) begin
			sense_ctrl_low_r <= {2'h0, pwdata[5:0]}; // RULE3
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_r <= 3'h0;
		end else if (wr && sel_m) begin
			mask_r <= pwdata[2:0];
		end
	end

	// ==========================================
	// Per-pin sense and pending flags
	genvar g;
	generate
		for (g = 0; g < `NUM_PINS; g = g + 1) begin : g_pin
			// Write of 0 only clears a flag that was 1 in the access phase of an earlier read
			assign clr_wr[g] = wr & sel_f & ~pwdata[g] & read_one_r[g]; // RULE5 RULE8
			pin_sense u_pin (
				.pclk(pclk),
				.presetn(presetn),
				.pin_async(ext_interrupt_pin[g]),
				.sense_mode(sense_ctrl_low_r[2 * g +: 2]), // RULE3
				.clr_by_write(clr_wr[g]),
				.exc_ack(exc_ack[g]),
				.pin_level(),
				.set_event(set_ev[g]),
				.flag_r(flag[g])
			);
		end
	endgenerate

	// Read-as-1 arm; disarmed once the flag is gone
	always @* begin
		read_one_nxt = read_one_r & flag;
		if (rd && sel_f) begin
			read_one_nxt = read_one_nxt | flag; // RULE5
		end
		if (wr && sel_f) begin
			read_one_nxt = read_one_nxt & ~clr_wr;
		end
	end

	// ==========================================
	// Sticky status: set wins over write-one clear
	assign status_clr = (wr && sel_s) ? pwdata[2:0] : 3'h0;

	always @* begin
		status_nxt = status_r & ~status_clr;
		status_nxt = status_nxt | set_ev;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			read_one_r <= 3'h0;
		end else begin
			read_one_r <= read_one_nxt;
		end
	end

	// Level mode keeps re-setting status while the pin stays low
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_r <= 3'h0;
		end else begin
			status_r <= status_nxt;
		end
	end

	assign irq = |(status_r & mask_r);
	assign pin_request = flag;

	// ==========================================
	// Priority level per source
	assign prio_pin0 = priority_ctrl_a_r[`PA_EXT0]; // RULE2
	assign prio_pin1 = priority_ctrl_a_r[`PA_EXT1]; // RULE2
	assign prio_pin2 = priority_ctrl_a_r[`PA_EXT2]; // RULE2
	assign prio_xfer = priority_ctrl_a_r[`PA_XFER]; // RULE2
	assign prio_wdog0 = priority_ctrl_a_r[`PA_WDOG0]; // RULE2
	assign prio_wdog1 = priority_ctrl_a_r[`PA_WDOG1]; // RULE2
	assign prio_conv = priority_ctrl_b_r[`PB_CONV]; // RULE2
	assign prio_frt = priority_ctrl_b_r[`PB_FRT]; // RULE2
	assign prio_tmr1 = priority_ctrl_b_r[`PB_TMR1]; // RULE2
	assign prio_tmrxy = priority_ctrl_b_r[`PB_TMRXY]; // RULE2
	assign prio_ser0 = priority_ctrl_c_r[`PC_SER0]; // RULE2
	assign prio_ser1 = priority_ctrl_c_r[`PC_SER1]; // RULE2
	assign prio_twc0 = priority_ctrl_c_r[`PC_TWC0]; // RULE2
	assign prio_twc1 = priority_ctrl_c_r[`PC_TWC1]; // RULE2

	assign pin_priority = {
		prio_pin2,
		prio_pin1,
		prio_pin0
	}; // RULE1
	// Unused bit positions of the three bytes stay plain storage
	assign src_priority = {
		prio_twc1,
		prio_twc0,
		prio_ser1,
		prio_ser0,
		prio_tmrxy,
		prio_tmr1,
		prio_frt,
		prio_conv,
		prio_wdog1,
		prio_wdog0,
		prio_xfer,
		prio_pin2,
		prio_pin1,
		prio_pin0
	}; // RULE2

	// ==========================================
	// Read mux, registered data lane
	// Select is a pure function of the setup-phase address
	always @* begin
		prdata_nxt = 32'h00000000;
		case (1'b1)
			sel_a: prdata_nxt[7:0] = priority_ctrl_a_r;
			sel_b: prdata_nxt[7:0] = priority_ctrl_b_r;
			sel_c: prdata_nxt[7:0] = priority_ctrl_c_r;
			sel_f: prdata_nxt[7:0] = {5'h00, flag};
			sel_h: prdata_nxt[7:0] = sense_ctrl_high_r;
			sel_l: prdata_nxt[7:0] = sense_ctrl_low_r;
			sel_s: prdata_nxt[7:0] = {5'h00, status_r};
			sel_m: prdata_nxt[7:0] = {5'h00, mask_r};
			default: prdata_nxt = 32'h00000000;
		endcase
	end

	// Loaded in setup so the access phase needs no wait state
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= prdata_nxt;
		end
	end
endmodule // ext_irq_sense_priority_ctrl

// file: bench/irq_chk_chk.sv
`timescale 1ns/1ps
`include "irq_ctrl_map.vh"
// ====
// Port checks
module irq_chk(
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	input wire [2:0] ext_interrupt_pin,
	input wire [2:0] exc_ack,
	input wire [2:0] pin_request,
	input wire [2:0] pin_priority,
	input wire [13:0] src_priority
);
	wire [29:0] idx = paddr[31:2];
	wire wr = psel && penable && pwrite && pstrb[0];
	wire [2:0] pa = {pwdata[5], pwdata[6], pwdata[7]};
	wire [3:0] pb = {pwdata[1], pwdata[2], pwdata[6], pwdata[7]};
	wire [3:0] pc = {pwdata[3], pwdata[4], pwdata[6], pwdata[7]};
	reg [1:0] m0_r;
	// Shadow of pin 0 sense mode
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			m0_r <= 2'h0;
		else if (wr && idx == `REG_SENSE_CTRL_LOW)
			m0_r <= pwdata[1:0];
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_prio_a;
		wr && idx == `REG_PRIORITY_CTRL_A |=> pin_priority == $past(pa);
	endproperty
	a_prio_a: assert property (p_prio_a) else $error("pin priority wrong");
	property p_prio_b;
		wr && idx == `REG_PRIORITY_CTRL_B |=> src_priority[9:6] == $past(pb);
	endproperty
	a_prio_b: assert property (p_prio_b) else $error("b priority wrong");
	property p_prio_c;
		wr && idx == `REG_PRIORITY_CTRL_C |=> src_priority[13:10] == $past(pc);
	endproperty
	a_prio_c: assert property (p_prio_c) else $error("c priority wrong");
	property p_src;
		src_priority[2:0] == pin_priority;
	endproperty
	a_src: assert property (p_src) else $error("pin sources differ");
	property p_flag_clr;
		|($past(pin_request) & ~pin_request & ~$past(exc_ack))
			|-> $past(wr && idx == `REG_PIN_PENDING_FLAGS);
	endproperty
	a_flag_clr: assert property (p_flag_clr) else $error("flag fell alone");
	property p_w1;
		wr && idx == `REG_PIN_PENDING_FLAGS && pwdata[2:0] == 3'h7 && exc_ack == 3'h0
			|=> (pin_request | ~$past(pin_request)) == 3'h7;
	endproperty
	a_w1: assert property (p_w1) else $error("one cleared flag");
	property p_edge;
		(m0_r[0] && $fell(ext_interrupt_pin[0])) || (m0_r[1] && $rose(ext_interrupt_pin[0]))
			|-> ##[2:4] pin_request[0];
	endproperty
	a_edge: assert property (p_edge) else $error("edge missed");
	property p_low;
		m0_r == `SENSE_LOW && !ext_interrupt_pin[0] [*5] |-> pin_request[0];
	endproperty
	a_low: assert property (p_low) else $error("low level missed");
endmodule // irq_chk

// file: bench/core_model.sv
`timescale 1ns/1ps
// ====
// Core side: services pending pins
module core_model(
	input wire pclk,
	input wire presetn,
	input wire serve,
	input wire [2:0] pin_request,
	output reg [2:0] exc_ack
);
	// Alternate so each ack is one cycle wide
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			exc_ack <= 3'h0;
		else
			exc_ack <= serve ? pin_request & ~exc_ack : 3'h0;
	end
endmodule // core_model

// file: bench/ext_irq_sense_priority_ctrl_tb.sv
`timescale 1ns/1ps
`include "irq_ctrl_map.vh"
`define CHK(a,b) begin checks++; if ((a) !== (b)) begin fail_count++; $display("ERROR %0t %h %h", $time, a, b); end end
module ext_irq_sense_priority_ctrl_tb;
	reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, serve = 0, err;
	reg [31:0] paddr = 0, pwdata = 0, rd;
	reg [2:0] pins = 3'h7;
	wire [31:0] prdata;
	wire pready, pslverr, irq;
	wire [2:0] ack, req, pp;
	wire [13:0] sp;
	int fail_count = 0, checks = 0, cyc = 0, i;
	// Sense pattern, flags after fall, flags after clear and rise
	reg [11:0] rows [4] = '{12'h91D, 12'hE6E, 12'h3B7, 12'h4FB};
	ext_irq_sense_priority_ctrl i_dut(.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_interrupt_pin(pins),
		.exc_ack(ack), .pin_request(req), .pin_priority(pp), .src_priority(sp), .irq(irq));
	core_model i_core(.pclk(pclk), .presetn(presetn), .serve(serve), .pin_request(req),
		.exc_ack(ack));
	initial begin
		forever #12.5 pclk = ~pclk;
	end
	task apb(input bit w, input [15:0] a, input [7:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= {14'h0, a, 2'h0};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task clr;
		apb(0, `REG_PIN_PENDING_FLAGS, 8'h00);
		apb(1, `REG_PIN_PENDING_FLAGS, 8'h00);
	endtask
	task rest(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task test_done;
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc > 5000) begin
			fail_count++;
			test_done;
		end
	end
	initial begin
		rest(3);
		presetn <= 1;
		for (i = `REG_PRIORITY_CTRL_A; i <= `REG_SENSE_CTRL_LOW; i++) begin
			apb(0, i[15:0], 8'h00);
			`CHK(rd, 32'h0)
		end
		for (i = 0; i < 4; i++) begin
			apb(1, `REG_SENSE_CTRL_LOW, {2'h0, rows[i][11:6]});
			clr;
			pins <= 3'h0;
			rest(6);
			apb(0, `REG_PIN_PENDING_FLAGS, 8'h00);
			`CHK(rd[2:0], rows[i][5:3])
			clr;
			pins <= 3'h7;
			rest(6);
			apb(0, `REG_PIN_PENDING_FLAGS, 8'h00);
			`CHK(rd[2:0], rows[i][2:0])
		end
		apb(1, `REG_PRIORITY_CTRL_A, 8'hA5);
		apb(1, `REG_PRIORITY_CTRL_B, 8'h82);
		apb(1, `REG_PRIORITY_CTRL_C, 8'h90);
		rest(1);
		`CHK(sp, 14'h166D)
		`CHK(pp, 3'h5)
		`CHK(irq, 1'h0)
		apb(1, `REG_IRQ_MASK, 8'h07);
		rest(1);
		`CHK(irq, 1'h1)
		apb(1, `REG_IRQ_STATUS, 8'h07);
		rest(1);
		`CHK(irq, 1'h0)
		// Pin 0 on falling edge, others idle high
		apb(1, `REG_SENSE_CTRL_LOW, 8'h01);
		clr;
		pins <= 3'h6;
		rest(6);
		apb(1, `REG_PIN_PENDING_FLAGS, 8'h00);
		`CHK(req[0], 1'h1)
		apb(0, `REG_PIN_PENDING_FLAGS, 8'h00);
		apb(1, `REG_PIN_PENDING_FLAGS, 8'h07);
		`CHK(req[0], 1'h1)
		apb(1, `REG_PIN_PENDING_FLAGS, 8'h06);
		rest(1);
		`CHK(req[0], 1'h0)
		pins <= 3'h7;
		rest(6);
		pins <= 3'h6;
		rest(6);
		`CHK(req[0], 1'h1)
		serve <= 1;
		rest(4);
		`CHK(req[0], 1'h0)
		apb(1, `REG_SENSE_CTRL_LOW, 8'h00);
		rest(6);
		`CHK(req[0], 1'h1)
		pins <= 3'h7;
		rest(8);
		`CHK(req[0], 1'h0)
		serve <= 0;
		apb(0, 16'hFEF8, 8'h00);
		`CHK(err, 1'h1)
		`CHK(pready, 1'h1)
		`CHK(rd, 32'h0)
		test_done;
	end
endmodule // ext_irq_sense_priority_ctrl_tb
bind ext_irq_sense_priority_ctrl irq_chk u_chk(.*);
